// *** logic/cpux_exc_seq.sv ***
`timescale 1ns/1ps
// ****************************************
// Exception sequencer
// ****************************************
// How it works
// - Simultaneous exceptions go reset, address error, trace, then interrupt.
// - Instruction exceptions never coincide with others, so need no arbitration.
// - Reset sequence starts right after the reset pin rises.
// - Trace flag set means a trace exception at each instruction end.
// - Interrupts sampled at instruction end and at exception sequence end.
// - Undefined, trap and zero-divide exceptions come from the instruction itself.
// - Non-reset entry pushes PC, code page (max mode), status; clears trace; vectors.
// - Interrupt entry also updates the priority mask field.
// - Reset entry pushes nothing.
// - Vectors sit at page 0 bottom; entries two bytes min, four max.
// - Undefined, zero-divide, overflow-trap vectors at 4, 6, 8 (doubled in max).
// - Address error, trace, NMI vectors at 10, 12, 16 hex (doubled in max).
// - Vectored trap picks one of sixteen consecutive entries from 20 hex.
// - Reset halts everything and initialises state; RAM is untouched.
// - Leaving reset clears trace and sets mask to 7.
// - Minimum mode reset loads PC from the word at address zero.
// - Maximum mode reset drops byte 0, byte 1 to code page, bytes 2-3 PC.
// - Reset leaves the stack pointer untouched.
// - First instruction after reset and instruction after control load run uninterrupted.
// - Address error entry clears trace, keeps the mask.
// - Prefetch from the register field is an address error.
// - Prefetch error waits for instruction end; stacked PC is the next one.
// - Odd word access is an address error; stacked PC is past the instruction.
// - Interrupt entry sets the mask to the accepted level, or to 7 for NMI.
// - Single-chip access to unpopulated addresses is an address error.
module cpux_exc_seq (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  // Mode pins
  input wire logic MAX_MODE_I,
  input wire logic SINGLE_CHIP_I,
  // Instruction sequencer
  input wire logic INSN_END_I,
  input wire logic CTL_LOAD_I,
  input wire cpux_pkg::cpux_iexc_t INSN_EXC_I,
  input wire cpux_pkg::cpux_ctx_t CTX_I,
  output logic HOLD_O,
  output logic LOAD_O,
  output cpux_pkg::cpux_ctx_t CTX_O,
  output cpux_pkg::cpux_exc_t KIND_O,
  // Bus watch
  input wire cpux_pkg::cpux_acc_t ACC_I,
  // Interrupt controller
  input wire cpux_pkg::cpux_irq_t IRQ_I,
  output logic IRQ_ACK_O,
  // Memory bus
  output cpux_pkg::cpux_mem_t MEM_O,
  input wire logic MEM_ACK_I,
  input wire logic [15:0] MEM_RDATA_I
);
  import cpux_pkg::*;

  // ****************************************
  // Types and helpers
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PUSH_PC = 3'h1,
    S_PUSH_CP = 3'h2,
    S_PUSH_SR = 3'h3,
    S_VEC_HI = 3'h4,
    S_VEC_LO = 3'h5
  } cpux_state_t;

  function automatic cpux_mem_t mem_rd(input logic [15:0] a);
    cpux_mem_t m;
    m = MEM_IDLE;
    m.req = 1'b1;
    m.addr = a;
    return m;
  endfunction : mem_rd

  function automatic cpux_mem_t mem_wr(input logic [15:0] a, input logic [15:0] d);
    cpux_mem_t m;
    m = MEM_IDLE;
    m.req = 1'b1;
    m.we = 1'b1;
    m.addr = a;
    m.wdata = d;
    return m;
  endfunction : mem_wr

  // Vector address; maximum mode doubles every entry
  function automatic logic [15:0] vec_of(input cpux_exc_t k, input logic [3:0] n,
                                         input cpux_irq_t q, input logic mx);
    logic [15:0] v;
    case (k)
      EXC_RESET: v = VEC_RESET;
      EXC_INVALID: v = VEC_INVALID;
      EXC_ZDIV: v = VEC_ZDIV;
      EXC_TRAPVS: v = VEC_TRAPVS;
      EXC_ADDR: v = VEC_ADDR;
      EXC_TRACE: v = VEC_TRACE;
      EXC_VECTORED_TRAP_OP: v = VEC_VECTORED_TRAP_OP + {11'h000, n, 1'b0};
      EXC_INT: v = q.nmi ? VEC_NMI : {8'h00, q.vec};
      default: v = VEC_RESET;
    endcase
    return mx ? {v[14:0], 1'b0} : v;
  endfunction : vec_of

  // New status word on entry
  function automatic logic [15:0] sr_entry(input logic [15:0] s, input cpux_exc_t k,
                                           input cpux_irq_t q);
    logic [15:0] r;
    r = s;
    r[SR_T_BIT] = 1'b0;
    if (k == EXC_INT) begin
      r[SR_MASK_LSB +: 3] = q.nmi ? MASK_NMI : q.level;
    end
    return r;
  endfunction : sr_entry

  function automatic logic int_ok(input cpux_irq_t q, input logic [15:0] s, input logic blk);
    return q.valid && !blk && (q.nmi || (q.level > s[SR_MASK_LSB +: 3]));
  endfunction : int_ok

  // ****************************************
  // Pins and address errors
  // ****************************************
  logic [1:0] mode_q;
  logic max_mode;
  logic single_chip;
  logic addr_err;

  cpux_pin_sync #(
    .W(2)
  ) u_mode_sync (
    .clk_i(SYS_CLK_I),
    .pin_i({MAX_MODE_I, SINGLE_CHIP_I}),
    .q_o(mode_q)
  );

  assign max_mode = mode_q[1];
  assign single_chip = mode_q[0];

  cpux_addr_chk u_addr_chk (
    .acc_i(ACC_I),
    .single_chip_i(single_chip),
    .err_o(addr_err)
  );

  // ****************************************
  // Sequencer state
  // ****************************************
  cpux_state_t state_r;
  cpux_state_t state_nxt;
  cpux_exc_t kind_r;
  cpux_exc_t kind_nxt;
  cpux_ctx_t ctx_r;
  cpux_ctx_t ctx_nxt;
  logic [15:0] sav_sr_r;
  logic [15:0] sav_sr_nxt;
  logic [15:0] vec_r;
  logic [15:0] vec_nxt;
  cpux_mem_t mem_r;
  cpux_mem_t mem_nxt;
  logic load_r;
  logic load_nxt;
  logic ack_r;
  logic ack_nxt;
  logic started_r;
  logic started_nxt;
  logic block_r;
  logic block_nxt;
  logic apend_r;
  logic apend_nxt;
  logic enter;
  logic finish;
  cpux_exc_t enter_kind;
  cpux_ctx_t base;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    ctx_nxt = ctx_r;
    sav_sr_nxt = sav_sr_r;
    vec_nxt = vec_r;
    mem_nxt = mem_r;
    load_nxt = 1'b0;
    ack_nxt = 1'b0;
    started_nxt = started_r;
    block_nxt = block_r;
    // A new error in the clearing cycle is kept
    apend_nxt = apend_r || addr_err;
    enter = 1'b0;
    finish = 1'b0;
    enter_kind = EXC_NONE;
    base = CTX_I;
    unique case (state_r)
      S_IDLE: begin
        if (!started_r) begin
          started_nxt = 1'b1;
          kind_nxt = EXC_RESET;
          ctx_nxt.sr = SR_RESET;
          ctx_nxt.sp = CTX_I.sp;
          vec_nxt = vec_of(EXC_RESET, 4'h0, IRQ_I, max_mode);
          mem_nxt = mem_rd(vec_of(EXC_RESET, 4'h0, IRQ_I, max_mode));
          state_nxt = S_VEC_HI;
        end else if (INSN_END_I) begin
          block_nxt = 1'b0;
          if (apend_r || addr_err) begin
            enter = 1'b1;
            enter_kind = EXC_ADDR;
          end else if (CTX_I.sr[SR_T_BIT]) begin
            enter = 1'b1;
            enter_kind = EXC_TRACE;
          end else if (int_ok(IRQ_I, CTX_I.sr, block_r || CTL_LOAD_I)) begin
            enter = 1'b1;
            enter_kind = EXC_INT;
          end
        end else if (INSN_EXC_I.valid) begin
          enter = 1'b1;
          enter_kind = INSN_EXC_I.kind;
        end
      end
      S_PUSH_PC: begin
        if (MEM_ACK_I) begin
          ctx_nxt.sp = ctx_r.sp - STACK_STEP;
          if (max_mode) begin
            mem_nxt = mem_wr(ctx_r.sp - STACK_STEP, {8'h00, ctx_r.cp});
            state_nxt = S_PUSH_CP;
          end else begin
            mem_nxt = mem_wr(ctx_r.sp - STACK_STEP, sav_sr_r);
            state_nxt = S_PUSH_SR;
          end
        end
      end
      S_PUSH_CP: begin
        if (MEM_ACK_I) begin
          ctx_nxt.sp = ctx_r.sp - STACK_STEP;
          mem_nxt = mem_wr(ctx_r.sp - STACK_STEP, sav_sr_r);
          state_nxt = S_PUSH_SR;
        end
      end
      S_PUSH_SR: begin
        if (MEM_ACK_I) begin
          mem_nxt = mem_rd(vec_r);
          state_nxt = S_VEC_HI;
        end
      end
      S_VEC_HI: begin
        if (MEM_ACK_I) begin
          if (max_mode) begin
            // High byte of the first word is ignored
            ctx_nxt.cp = MEM_RDATA_I[7:0];
            mem_nxt = mem_rd(vec_r + VEC_WORD_STEP);
            state_nxt = S_VEC_LO;
          end else begin
            ctx_nxt.pc = MEM_RDATA_I;
            finish = 1'b1;
          end
        end
      end
      S_VEC_LO: begin
        if (MEM_ACK_I) begin
          ctx_nxt.pc = MEM_RDATA_I;
          finish = 1'b1;
        end
      end
    endcase
    if (finish) begin
      mem_nxt = MEM_IDLE;
      state_nxt = S_IDLE;
      if (kind_r == EXC_RESET) begin
        block_nxt = 1'b1;
        load_nxt = 1'b1;
      end else if (int_ok(IRQ_I, ctx_nxt.sr, 1'b0)) begin
        // Chain straight into the interrupt; the handler address is what gets stacked
        enter = 1'b1;
        enter_kind = EXC_INT;
        base = ctx_nxt;
      end else begin
        load_nxt = 1'b1;
      end
    end
    if (enter) begin
      kind_nxt = enter_kind;
      sav_sr_nxt = base.sr;
      ctx_nxt = base;
      ctx_nxt.sr = sr_entry(base.sr, enter_kind, IRQ_I);
      ctx_nxt.sp = base.sp - STACK_STEP;
      vec_nxt = vec_of(enter_kind, INSN_EXC_I.num, IRQ_I, max_mode);
      mem_nxt = mem_wr(base.sp - STACK_STEP, base.pc);
      state_nxt = S_PUSH_PC;
      ack_nxt = (enter_kind == EXC_INT);
      if (enter_kind == EXC_ADDR) begin
        apend_nxt = addr_err;
      end
    end
  end

  // Everything returns to constants while reset is low
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r <= S_IDLE;
      kind_r <= EXC_NONE;
      ctx_r <= '{pc: PC_RESET, cp: CP_RESET, sr: SR_RESET, sp: 16'h0000};
      sav_sr_r <= SR_RESET;
      vec_r <= VEC_RESET;
      mem_r <= MEM_IDLE;
      load_r <= 1'b0;
      ack_r <= 1'b0;
      started_r <= 1'b0;
      block_r <= 1'b1;
      apend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      ctx_r <= ctx_nxt;
      sav_sr_r <= sav_sr_nxt;
      vec_r <= vec_nxt;
      mem_r <= mem_nxt;
      load_r <= load_nxt;
      ack_r <= ack_nxt;
      started_r <= started_nxt;
      block_r <= block_nxt;
      apend_r <= apend_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Hold reacts in the entry cycle so the CPU never fetches past a taken exception
  assign HOLD_O = (state_r != S_IDLE) || !started_r || enter;
  assign LOAD_O = load_r;
  assign CTX_O = ctx_r;
  assign KIND_O = kind_r;
  assign IRQ_ACK_O = ack_r;
  assign MEM_O = mem_r;

endmodule : cpux_exc_seq

// *** logic/cpux_pkg.sv ***
// ****************************************
// Exception sequencer shared definitions
// ****************************************
package cpux_pkg;

  // Exception kinds
  typedef enum logic [3:0] {
    EXC_NONE = 4'h0,
    EXC_RESET = 4'h1,
    EXC_ADDR = 4'h2,
    EXC_TRACE = 4'h3,
    EXC_INT = 4'h4,
    EXC_INVALID = 4'h5,
    EXC_ZDIV = 4'h6,
    EXC_TRAPVS = 4'h7,
    EXC_VECTORED_TRAP_OP = 4'h8
  } cpux_exc_t;

  // Status word layout and reset values
  localparam int SR_T_BIT = 15;
  localparam int SR_MASK_LSB = 8;
  localparam logic [15:0] SR_RESET = 16'h0700;
  localparam logic [2:0] MASK_NMI = 3'h7;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] CP_RESET = 8'h00;

  // Stack and vector stepping
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] VEC_WORD_STEP = 16'h0002;

  // Vector entries, minimum-mode addresses
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_INVALID = 16'h0004;
  localparam logic [15:0] VEC_ZDIV = 16'h0006;
  localparam logic [15:0] VEC_TRAPVS = 16'h0008;
  localparam logic [15:0] VEC_ADDR = 16'h0010;
  localparam logic [15:0] VEC_TRACE = 16'h0012;
  localparam logic [15:0] VEC_NMI = 16'h0016;
  localparam logic [15:0] VEC_VECTORED_TRAP_OP = 16'h0020;

  // Address ranges checked for address errors
  localparam logic [15:0] REG_FIELD_LO = 16'hFE80;
  localparam logic [15:0] REG_FIELD_HI = 16'hFFFF;
  localparam logic [15:0] OFFCHIP_LO = 16'h8000;
  localparam logic [15:0] OFFCHIP_HI = 16'hF67F;

  // CPU context handed in and out
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] cp;
    logic [15:0] sr;
    logic [15:0] sp;
  } cpux_ctx_t;

  // Instruction-caused exception request
  typedef struct packed {
    logic valid;
    cpux_exc_t kind;
    logic [3:0] num;
  } cpux_iexc_t;

  // Accepted interrupt from the interrupt controller
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [2:0] level;
    logic [7:0] vec;
  } cpux_irq_t;

  // Bus access seen by the address checker
  typedef struct packed {
    logic valid;
    logic fetch;
    logic word;
    logic [15:0] addr;
  } cpux_acc_t;

  // Memory request of the sequencer
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cpux_mem_t;

  localparam cpux_mem_t MEM_IDLE = '{req: 1'b0, we: 1'b0, addr: 16'h0000, wdata: 16'h0000};

endpackage : cpux_pkg

// *** logic/cpux_pin_sync.sv ***
`timescale 1ns/1ps
// ****************************************
// Pin synchroniser, three stages
// ****************************************
module cpux_pin_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk_i,
  // Pin and result
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] q_o
);

  // Refused at elaboration rather than at run time
  if (W < 1) begin : g_w_check
    $error("cpux_pin_sync: W must be at least 1");
  end

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // A change counts once stages two and three agree
  always_comb begin
    q_nxt = q_r;
    if (s2_r == s3_r) begin
      q_nxt = s3_r;
    end
  end

  // No reset: mode straps must already be valid while the chip reset is held
  always_ff @(posedge clk_i) begin
    s1_r <= pin_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
    q_r <= q_nxt;
  end

  assign q_o = q_r;

endmodule : cpux_pin_sync

// *** logic/cpux_addr_chk.sv ***
`timescale 1ns/1ps
// ****************************************
// Address error detection
// ****************************************
module cpux_addr_chk (
  // Access under watch
  input wire cpux_pkg::cpux_acc_t acc_i,
  input wire logic single_chip_i,
  // Result
  output logic err_o
);
  import cpux_pkg::*;

  logic in_reg_field;
  logic in_offchip;
  logic odd_word;

  always_comb begin
    in_reg_field = (acc_i.addr >= REG_FIELD_LO) && (acc_i.addr <= REG_FIELD_HI);
    in_offchip = (acc_i.addr >= OFFCHIP_LO) && (acc_i.addr <= OFFCHIP_HI);
    odd_word = acc_i.word && !acc_i.fetch && acc_i.addr[0];
    err_o = acc_i.valid && (
      (acc_i.fetch && in_reg_field) ||
      odd_word ||
      (single_chip_i && in_offchip));
  end

endmodule : cpux_addr_chk

// *** tb/cpux_exc_seq_sva.sv ***
`timescale 1ns/1ps
// ****************************************
// Exception sequencer checker
// ****************************************
module cpux_exc_seq_sva (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  // Instruction side
  input wire logic INSN_END_I,
  input wire logic CTL_LOAD_I,
  input wire cpux_pkg::cpux_iexc_t INSN_EXC_I,
  input wire cpux_pkg::cpux_ctx_t CTX_I,
  input wire logic HOLD_O,
  input wire logic LOAD_O,
  input wire cpux_pkg::cpux_ctx_t CTX_O,
  input wire cpux_pkg::cpux_exc_t KIND_O,
  // Bus, interrupt and memory
  input wire cpux_pkg::cpux_acc_t ACC_I,
  input wire cpux_pkg::cpux_irq_t IRQ_I,
  input wire logic IRQ_ACK_O,
  input wire cpux_pkg::cpux_mem_t MEM_O,
  input wire logic MEM_ACK_I
);
  import cpux_pkg::*;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Idle instruction end: hold was low the cycle before
  sequence s_idle_end;
    INSN_END_I && !$past(HOLD_O);
  endsequence
  sequence s_addr_entry;
    HOLD_O ##1 (KIND_O == EXC_ADDR);
  endsequence
  reset_start_a: assert property ($rose(RST_B_I) |=> MEM_O.req && !MEM_O.we &&
    MEM_O.addr == VEC_RESET && KIND_O == EXC_RESET) else $error("reset vector read missing");
  reset_no_push_a: assert property ((KIND_O == EXC_RESET && MEM_O.req) |-> !MEM_O.we)
    else $error("reset wrote memory");
  reset_sr_a: assert property ((LOAD_O && KIND_O == EXC_RESET) |-> CTX_O.sr == SR_RESET)
    else $error("reset status word wrong");
  load_trace_a: assert property (LOAD_O |-> !CTX_O.sr[SR_T_BIT] && !HOLD_O)
    else $error("trace flag kept at load");
  insn_kind_a: assert property ((INSN_EXC_I.valid && !$past(HOLD_O)) |->
    HOLD_O ##1 KIND_O == $past(INSN_EXC_I.kind)) else $error("instruction exception missed");
  trace_entry_a: assert property (s_idle_end ##0 CTX_I.sr[SR_T_BIT] |->
    HOLD_O ##1 KIND_O inside {EXC_TRACE, EXC_ADDR}) else $error("trace missed");
  odd_word_a: assert property ((ACC_I.valid && ACC_I.word && !ACC_I.fetch && ACC_I.addr[0]
    && !HOLD_O) ##1 s_idle_end |-> s_addr_entry) else $error("odd word not trapped");
  fetch_reg_a: assert property ((ACC_I.valid && ACC_I.fetch && ACC_I.addr >= REG_FIELD_LO
    && !HOLD_O) ##1 s_idle_end |-> s_addr_entry) else $error("register fetch not trapped");
  irq_ack_a: assert property (IRQ_ACK_O |-> $past(IRQ_I.valid) && HOLD_O)
    else $error("ack without request");
  irq_block_a: assert property ((INSN_END_I && CTL_LOAD_I && !$past(HOLD_O)) |=> !IRQ_ACK_O)
    else $error("interrupt after control load");
  mem_hold_a: assert property ((MEM_O.req && !MEM_ACK_I) |=> $stable(MEM_O))
    else $error("memory request changed early");
endmodule : cpux_exc_seq_sva

bind cpux_exc_seq cpux_exc_seq_sva i_sva (.SYS_CLK_I, .RST_B_I, .INSN_END_I, .CTL_LOAD_I, .INSN_EXC_I,
  .CTX_I, .HOLD_O, .LOAD_O, .CTX_O, .KIND_O, .ACC_I, .IRQ_I, .IRQ_ACK_O, .MEM_O, .MEM_ACK_I);

// *** tb/cpux_mem_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Memory partner model
// ****************************************
module cpux_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Request and answer
  input wire cpux_pkg::cpux_mem_t mem_i,
  input wire logic [1:0] lat_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  import cpux_pkg::*;
  logic [15:0] mem [0:1023];
  logic [1:0] cnt_r;
  logic [15:0] last_r;
  // Wait states stretch the answer; the request has to stand meanwhile
  assign ack_o = mem_i.req && cnt_r >= lat_i;
  // Outside the answer the data lines show the inverse of the last word
  assign rdata_o = ack_o ? mem[mem_i.addr[10:1]] : ~last_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 2'h0;
      last_r <= 16'h0000;
    end else begin
      cnt_r <= (mem_i.req && !ack_o) ? cnt_r + 2'h1 : 2'h0;
      last_r <= ack_o ? rdata_o : last_r;
    end
  end
  // Contents survive reset, as RAM does
  always @(posedge clk_i) begin
    if (ack_o && mem_i.we) mem[mem_i.addr[10:1]] <= mem_i.wdata;
  end
endmodule : cpux_mem_model

// *** tb/cpux_exc_seq_test.sv ***
`timescale 1ns/1ps
// ****************************************
// Exception sequencer testbench
// ****************************************
module cpux_exc_seq_test;
  import cpux_pkg::*;
  logic clk, rst_b, max_m, one_chip, ins_end, ctl_ld, ack, hold, load, irq_ack, hd;
  logic [1:0] lat;
  logic [15:0] rdata, pre;
  cpux_iexc_t iexc, ex;
  cpux_ctx_t ctx, ctx_o;
  cpux_acc_t acc;
  cpux_irq_t irq;
  cpux_exc_t kind;
  cpux_mem_t mem_o;
  cpux_exc_t kinds [4] = '{EXC_INVALID, EXC_ZDIV, EXC_TRAPVS, EXC_VECTORED_TRAP_OP};
  int miscompares = 0;
  int checks_done = 0;

  cpux_exc_seq i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .MAX_MODE_I(max_m), .SINGLE_CHIP_I(one_chip),
    .INSN_END_I(ins_end), .CTL_LOAD_I(ctl_ld), .INSN_EXC_I(iexc), .CTX_I(ctx), .HOLD_O(hold),
    .LOAD_O(load), .CTX_O(ctx_o), .KIND_O(kind), .ACC_I(acc), .IRQ_I(irq), .IRQ_ACK_O(irq_ack),
    .MEM_O(mem_o), .MEM_ACK_I(ack), .MEM_RDATA_I(rdata));
  cpux_mem_model i_mem (.clk_i(clk), .rst_b_i(rst_b), .mem_i(mem_o), .lat_i(lat), .ack_o(ack), .rdata_o(rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Interrupt controller drops its request once acknowledged
  always @(negedge clk) if (irq_ack === 1'b1) irq.valid = 1'b0;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  function automatic logic [15:0] ivec(input cpux_exc_t k, input logic [3:0] n);
    case (k)
      EXC_INVALID: return VEC_INVALID;
      EXC_ZDIV: return VEC_ZDIV;
      EXC_TRAPVS: return VEC_TRAPVS;
      default: return VEC_VECTORED_TRAP_OP + {11'h000, n, 1'b0};
    endcase
  endfunction : ivec

  task automatic new_ctx();
    ctx.pc = 16'($urandom);
    ctx.cp = 8'($urandom);
    ctx.sr = 16'($urandom) & 16'h7FFF;
    ctx.sp = 16'($urandom_range(16'h7F0, 16'h200)) & 16'hFFFE;
  endtask : new_ctx

  task automatic fire(input logic e, input cpux_iexc_t x, input logic cl, output logic h);
    ins_end = e;
    iexc = x;
    ctl_ld = cl;
    #1 h = hold;
    @(negedge clk);
    ins_end = 1'b0;
    iexc = '0;
    ctl_ld = 1'b0;
  endtask : fire

  task automatic wait_load();
    int n;
    n = 0;
    while (load !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("load", 16'h0001, {15'h0000, load});
  endtask : wait_load

  task automatic do_reset(input logic mx);
    rst_b = 1'b0;
    max_m = mx;
    new_ctx();
    pre = i_mem.mem[ctx.sp[10:1] - 1];
    repeat (20) @(negedge clk);
    chk("reset hold", 16'h0001, {15'h0000, hold});
    rst_b = 1'b1;
    wait_load();
    chk("reset pc", mx ? i_mem.mem[1] : i_mem.mem[0], ctx_o.pc);
    if (mx) chk("reset cp", {8'h00, i_mem.mem[0][7:0]}, {8'h00, ctx_o.cp});
    chk("reset sr", SR_RESET, ctx_o.sr);
    chk("reset sp", ctx.sp, ctx_o.sp);
    chk("reset stack", pre, i_mem.mem[ctx.sp[10:1] - 1]);
    @(negedge clk);
    ctx.sr = SR_RESET;
    irq = '{valid: 1'b1, nmi: 1'b1, level: 3'h7, vec: VEC_NMI[7:0]};
    fire(1'b1, '0, 1'b0, hd);
    chk("first insn hold", 16'h0000, {15'h0000, hd});
    irq = '0;
    @(negedge clk);
  endtask : do_reset

  // Vector v is the minimum-mode address; max mode doubles it and stacks three words
  task automatic entry(input logic mx, input logic [15:0] v, input logic [2:0] msk, input cpux_exc_t k);
    logic [15:0] va;
    va = mx ? {v[14:0], 1'b0} : v;
    wait_load();
    chk("kind", {12'h000, k}, {12'h000, kind});
    chk("pc", mx ? i_mem.mem[va[10:1] + 1] : i_mem.mem[va[10:1]], ctx_o.pc);
    if (mx) chk("cp", {8'h00, i_mem.mem[va[10:1]][7:0]}, {8'h00, ctx_o.cp});
    chk("sr", {1'b0, ctx.sr[14:11], msk, ctx.sr[7:0]}, ctx_o.sr);
    chk("sp", ctx.sp - (mx ? 16'h0006 : 16'h0004), ctx_o.sp);
    chk("pushed pc", ctx.pc, i_mem.mem[ctx.sp[10:1] - 1]);
    chk("pushed sr", ctx.sr, i_mem.mem[ctx.sp[10:1] - (mx ? 3 : 2)]);
    if (mx) chk("pushed cp", {8'h00, ctx.cp}, i_mem.mem[ctx.sp[10:1] - 2]);
    @(negedge clk);
  endtask : entry

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    max_m = 1'b0;
    one_chip = 1'b0;
    ins_end = 1'b0;
    ctl_ld = 1'b0;
    lat = 2'h0;
    iexc = '0;
    ctx = '0;
    acc = '0;
    irq = '0;
    void'($urandom(32'h6066C58B));
    for (int i = 0; i < 1024; i++) i_mem.mem[i] = 16'($urandom);
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      for (int i = 0; i < 12; i++) begin
        new_ctx();
        lat = 2'($urandom);
        ex = '{valid: 1'b1, kind: kinds[i % 4], num: (i == 3) ? 4'h0 : (i == 7) ? 4'hF : 4'($urandom)};
        fire(1'b0, ex, 1'b0, hd);
        chk("exc hold", 16'h0001, {15'h0000, hd});
        entry(m[0], ivec(ex.kind, ex.num), ctx.sr[10:8], ex.kind);
      end
      new_ctx();
      ctx.sr[15] = 1'b1;
      fire(1'b1, '0, 1'b0, hd);
      entry(m[0], VEC_TRACE, ctx.sr[10:8], EXC_TRACE);
      for (int i = 0; i < 3; i++) begin
        new_ctx();
        ctx.sr[15] = 1'b1;
        one_chip = (i == 2);
        repeat (4) @(negedge clk);
        acc = '{valid: 1'b1, fetch: i == 1, word: i == 0,
          addr: (i == 0) ? 16'h0421 : (i == 1) ? REG_FIELD_LO : OFFCHIP_LO};
        @(negedge clk);
        acc = '0;
        fire(1'b1, '0, 1'b0, hd);
        entry(m[0], VEC_ADDR, ctx.sr[10:8], EXC_ADDR);
      end
      one_chip = 1'b0;
      new_ctx();
      ctx.sr[10:8] = 3'h3;
      irq = '{valid: 1'b1, nmi: 1'b0, level: 3'h3, vec: 8'h40};
      fire(1'b1, '0, 1'b0, hd);
      chk("masked hold", 16'h0000, {15'h0000, hd});
      irq.level = 3'h5;
      @(negedge clk);
      fire(1'b1, '0, 1'b1, hd);
      chk("ctl load hold", 16'h0000, {15'h0000, hd});
      @(negedge clk);
      fire(1'b1, '0, 1'b0, hd);
      entry(m[0], 16'h0040, 3'h5, EXC_INT);
      new_ctx();
      ctx.sr[10:8] = 3'h2;
      irq = '{valid: 1'b1, nmi: 1'b0, level: 3'h6, vec: 8'h50};
      ex = '{valid: 1'b1, kind: EXC_VECTORED_TRAP_OP, num: 4'h0};
      fire(1'b0, ex, 1'b0, hd);
      // Trap runs straight into the interrupt, so the trap's outcome is what gets stacked
      ctx.pc = m[0] ? i_mem.mem[VEC_VECTORED_TRAP_OP + 1] : i_mem.mem[VEC_VECTORED_TRAP_OP[10:1]];
      if (m[0]) ctx.cp = i_mem.mem[VEC_VECTORED_TRAP_OP][7:0];
      ctx.sp = ctx.sp - (m[0] ? 16'h0006 : 16'h0004);
      entry(m[0], 16'h0050, 3'h6, EXC_INT);
      new_ctx();
      ctx.sr[10:8] = 3'h7;
      irq = '{valid: 1'b1, nmi: 1'b1, level: 3'h0, vec: VEC_NMI[7:0]};
      fire(1'b1, '0, 1'b0, hd);
      entry(m[0], VEC_NMI, MASK_NMI, EXC_INT);
    end
    end_of_test();
  end

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule : cpux_exc_seq_test
